//--- include/flic_pkg.sv
package flic_pkg;
   localparam int NSRC = 20;
   // register offsets on the plain register port
   localparam logic [3:0] OFF_EN0 = 4'h0;
   localparam logic [3:0] OFF_EN1 = 4'h1;
   localparam logic [3:0] OFF_EN2 = 4'h2;
   localparam logic [3:0] OFF_PL0 = 4'h3;
   localparam logic [3:0] OFF_PH0 = 4'h4;
   localparam logic [3:0] OFF_PL1 = 4'h5;
   localparam logic [3:0] OFF_PH1 = 4'h6;
   localparam logic [3:0] OFF_PL2 = 4'h7;
   localparam logic [3:0] OFF_PH2 = 4'h8;
   localparam logic [3:0] OFF_FLG0 = 4'h9;
   localparam logic [3:0] OFF_FLG1 = 4'hA;
   localparam logic [3:0] OFF_FLG2 = 4'hB;
   localparam logic [3:0] OFF_CTRL = 4'hC;
   localparam logic [3:0] OFF_STAT = 4'hD;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam int GLOBAL_EN_BIT = 7;
   // machine cycle phases: index 0..3 are phases one to four
   localparam logic [1:0] PH_THREE = 2'h2;
   localparam logic [1:0] PH_FOUR = 2'h3;
   localparam logic [1:0] CALL_LAST_MCYC = 2'h3;
   // bit of each source, by rank, in {ext2, ext, primary} enable/priority
   localparam logic [NSRC-1:0][4:0] SRC_POS = {
      5'h0C, 5'h15, 5'h14, 5'h13, 5'h12, 5'h11, 5'h0E, 5'h0D,
      5'h0B, 5'h0A, 5'h10, 5'h0F, 5'h08, 5'h06, 5'h05, 5'h04,
      5'h03, 5'h02, 5'h01, 5'h00};
   // fixed vector address of each source, rank 19 first
   localparam logic [NSRC-1:0][15:0] SRC_VEC = {
      16'h0063, 16'h009B, 16'h0093, 16'h008B, 16'h006B, 16'h0073,
      16'h005B, 16'h0053, 16'h004B, 16'h0043, 16'h0083, 16'h007B,
      16'h003B, 16'h0033, 16'h002B, 16'h0023, 16'h001B, 16'h0013,
      16'h000B, 16'h0003};
   localparam logic [NSRC-1:0] TIMER_CLR_MASK = 20'h0000A;
   localparam logic [NSRC-1:0] SERIAL_MASK = 20'h00110;
   localparam logic [NSRC-1:0] PIN_SRC_MASK = 20'h00005;
   localparam int SRC_EXT_A = 0;
   localparam int SRC_EXT_B = 2;
   typedef enum logic [0:0] {
      CALL_IDLE = 1'b0,
      CALL_RUN = 1'b1
   } flic_call_t;
   typedef struct packed {
      logic [1:0] phase;
      logic sync_a1;
      logic sync_a2;
      logic sync_b1;
      logic sync_b2;
      logic samp_a;
      logic samp_b;
      logic [7:0] en0;
      logic [7:0] en1;
      logic [7:0] en2;
      logic [7:0] pl0;
      logic [7:0] ph0;
      logic [7:0] pl1;
      logic [7:0] ph1;
      logic [7:0] pl2;
      logic [7:0] ph2;
      logic [1:0] edge_mode;
      logic [NSRC-1:0] flags;
      logic [NSRC-1:0] pend;
      logic [NSRC-1:0] snap;
      logic [3:0] in_service;
      flic_call_t call_st;
      logic [1:0] mcnt;
      logic [15:0] vector;
      logic cfg_wr;
      logic push;
      logic load;
      logic wake;
      logic [7:0] rdata;
   } flic_state_t;
endpackage

//--- core/flic_top.sv
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module flic_top (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_ext_input_a_n,
   input wire logic i_ext_input_b_n,
   input wire logic [19:0] i_src_event,
   input wire logic i_last_cycle,
   input wire logic i_instr_blocks,
   input wire logic i_return_from_interrupt,
   input wire logic i_power_down,
   output logic [1:0] o_phase,
   output logic o_call_busy,
   output logic o_push_pc,
   output logic o_load_pc,
   output logic [15:0] o_vector,
   output logic o_wakeup
);
   flic_pkg::flic_state_t s_r;
   flic_pkg::flic_state_t s_nxt;

   // two-bit level of one source
   function automatic logic [1:0] src_level(
      input logic [23:0] hi,
      input logic [23:0] lo,
      input int idx
   );
      logic [4:0] p;
      p = flic_pkg::SRC_POS[idx];
      return {hi[p], lo[p]};
   endfunction

   // highest in-service level, valid flag in bit 2
   function automatic logic [2:0] top_level(input logic [3:0] isr);
      logic [2:0] t;
      t = 3'h0;
      for (int k = 0; k < 4; k++) begin
         if (isr[k]) begin
            t = {1'b1, k[1:0]};
         end
      end
      return t;
   endfunction

   logic [23:0] en_all;
   logic [23:0] hi_all;
   logic [23:0] lo_all;
   logic [19:0] src_en;
   logic [19:0] flags_w;
   logic [19:0] set_now;
   logic [19:0] clr_mask;
   logic [19:0] ph_mask;
   logic [1:0] best_lvl;
   logic [4:0] best_idx;
   logic best_any;
   logic [2:0] isr_top;
   logic wr_cfg;
   logic grant;
   logic fall_a;
   logic fall_b;

   always_comb begin
      s_nxt = s_r;
      en_all = {s_r.en2, s_r.en1, s_r.en0};
      hi_all = {s_r.ph2, s_r.ph1, s_r.ph0};
      lo_all = {s_r.pl2, s_r.pl1, s_r.pl0};
      src_en = 20'h00000;
      best_lvl = 2'h0;
      best_idx = 5'h00;
      best_any = 1'b0;
      set_now = 20'h00000;
      clr_mask = 20'h00000;
      ph_mask = 20'h00000;
      fall_a = 1'b0;
      fall_b = 1'b0;
      s_nxt.phase = s_r.phase + 2'h1;
      s_nxt.push = 1'b0;
      s_nxt.load = 1'b0;
      s_nxt.rdata = flic_pkg::RST_BYTE;

      // external pins pass two flops before use
      s_nxt.sync_a1 = i_ext_input_a_n;
      s_nxt.sync_a2 = s_r.sync_a1;
      s_nxt.sync_b1 = i_ext_input_b_n;
      s_nxt.sync_b2 = s_r.sync_b1;

      for (int i = 0; i < flic_pkg::NSRC; i++) begin
         src_en[i] = en_all[flic_pkg::SRC_POS[i]];
      end
      src_en = src_en & {20{s_r.en0[flic_pkg::GLOBAL_EN_BIT]}};

      // register writes
      wr_cfg = i_wr && (i_addr <= flic_pkg::OFF_PH2);
      flags_w = s_r.flags;
      if (i_wr) begin
         case (i_addr)
            flic_pkg::OFF_EN0: s_nxt.en0 = i_wdata;
            flic_pkg::OFF_EN1: s_nxt.en1 = i_wdata;
            flic_pkg::OFF_EN2: s_nxt.en2 = i_wdata;
            flic_pkg::OFF_PL0: s_nxt.pl0 = i_wdata;
            flic_pkg::OFF_PH0: s_nxt.ph0 = i_wdata;
            flic_pkg::OFF_PL1: s_nxt.pl1 = i_wdata;
            flic_pkg::OFF_PH1: s_nxt.ph1 = i_wdata;
            flic_pkg::OFF_PL2: s_nxt.pl2 = i_wdata;
            flic_pkg::OFF_PH2: s_nxt.ph2 = i_wdata;
            flic_pkg::OFF_FLG0: flags_w[7:0] = i_wdata;
            flic_pkg::OFF_FLG1: flags_w[15:8] = i_wdata;
            flic_pkg::OFF_FLG2: flags_w[19:16] = i_wdata[3:0];
            flic_pkg::OFF_CTRL: s_nxt.edge_mode = i_wdata[1:0];
            default: begin
            end
         endcase
      end

      // an enable or priority write in this machine cycle holds back the call
      if (s_r.phase == flic_pkg::PH_FOUR) begin
         s_nxt.cfg_wr = wr_cfg;
      end else begin
         s_nxt.cfg_wr = s_r.cfg_wr | wr_cfg;
      end

      // arbitration on the snapshot of the previous cycle
      for (int i = flic_pkg::NSRC - 1; i >= 0; i--) begin
         if (s_r.snap[i] &&
             (!best_any || src_level(hi_all, lo_all, i) >= best_lvl)) begin
            best_any = 1'b1;
            best_lvl = src_level(hi_all, lo_all, i);
            best_idx = i[4:0];
         end
      end
      isr_top = top_level(s_r.in_service);
      grant = best_any && (s_r.phase == flic_pkg::PH_FOUR) &&
              (s_r.call_st == flic_pkg::CALL_IDLE) &&
              (!isr_top[2] || best_lvl > isr_top[1:0]) &&
              i_last_cycle && !i_instr_blocks &&
              !s_r.cfg_wr && !wr_cfg;

      // automatic clear on vectoring
      if (grant) begin
         clr_mask = flic_pkg::TIMER_CLR_MASK;
         clr_mask[flic_pkg::SRC_EXT_A] = s_r.edge_mode[0];
         clr_mask[flic_pkg::SRC_EXT_B] = s_r.edge_mode[1];
         clr_mask = clr_mask & (20'h00001 << best_idx);
      end
      flags_w = flags_w & ~clr_mask;

      // peripheral events wait for their phase
      s_nxt.pend = s_r.pend | (i_src_event & ~flic_pkg::PIN_SRC_MASK);
      if (s_r.phase == flic_pkg::PH_THREE) begin
         ph_mask = ~flic_pkg::SERIAL_MASK;
      end else if (s_r.phase == flic_pkg::PH_FOUR) begin
         ph_mask = flic_pkg::SERIAL_MASK;
      end
      set_now = s_nxt.pend & ph_mask;
      s_nxt.pend = s_nxt.pend & ~ph_mask;

      // external inputs, active low, sampled at phase three
      if (s_r.phase == flic_pkg::PH_THREE) begin
         s_nxt.samp_a = s_r.sync_a2;
         s_nxt.samp_b = s_r.sync_b2;
         fall_a = s_r.samp_a && !s_r.sync_a2;
         fall_b = s_r.samp_b && !s_r.sync_b2;
         if (s_r.edge_mode[0]) begin
            set_now[flic_pkg::SRC_EXT_A] = fall_a;
         end else begin
            flags_w[flic_pkg::SRC_EXT_A] = !s_r.sync_a2;
         end
         if (s_r.edge_mode[1]) begin
            set_now[flic_pkg::SRC_EXT_B] = fall_b;
         end else begin
            flags_w[flic_pkg::SRC_EXT_B] = !s_r.sync_b2;
         end
      end
      // hardware set wins over any clear in the same clock
      s_nxt.flags = flags_w | set_now;

      // snapshot is rebuilt once per machine cycle, at phase four, nothing carried over
      if (s_r.phase == flic_pkg::PH_FOUR) begin
         s_nxt.snap = s_nxt.flags & src_en;
      end

      // hardware call sequence
      case (s_r.call_st)
         flic_pkg::CALL_IDLE: begin
            if (grant) begin
               s_nxt.call_st = flic_pkg::CALL_RUN;
               s_nxt.mcnt = 2'h0;
               s_nxt.vector = flic_pkg::SRC_VEC[best_idx];
               s_nxt.push = 1'b1;
               s_nxt.in_service[best_lvl] = 1'b1;
            end
         end
         flic_pkg::CALL_RUN: begin
            if (s_r.phase == flic_pkg::PH_FOUR) begin
               s_nxt.mcnt = s_r.mcnt + 2'h1;
               if (s_r.mcnt == flic_pkg::CALL_LAST_MCYC) begin
                  s_nxt.call_st = flic_pkg::CALL_IDLE;
                  s_nxt.load = 1'b1;
               end
            end
         end
         default: begin
            s_nxt.call_st = flic_pkg::CALL_IDLE;
         end
      endcase

      // return releases the most recent level
      if (i_return_from_interrupt && isr_top[2] && !grant) begin
         s_nxt.in_service[isr_top[1:0]] = 1'b0;
      end

      s_nxt.wake = i_power_down &&
                   ((s_r.flags[flic_pkg::SRC_EXT_A] &&
                     src_en[flic_pkg::SRC_EXT_A]) ||
                    (s_r.flags[flic_pkg::SRC_EXT_B] &&
                     src_en[flic_pkg::SRC_EXT_B]));

      if (i_rd) begin
         case (i_addr)
            flic_pkg::OFF_EN0: s_nxt.rdata = s_r.en0;
            flic_pkg::OFF_EN1: s_nxt.rdata = s_r.en1;
            flic_pkg::OFF_EN2: s_nxt.rdata = s_r.en2;
            flic_pkg::OFF_PL0: s_nxt.rdata = s_r.pl0;
            flic_pkg::OFF_PH0: s_nxt.rdata = s_r.ph0;
            flic_pkg::OFF_PL1: s_nxt.rdata = s_r.pl1;
            flic_pkg::OFF_PH1: s_nxt.rdata = s_r.ph1;
            flic_pkg::OFF_PL2: s_nxt.rdata = s_r.pl2;
            flic_pkg::OFF_PH2: s_nxt.rdata = s_r.ph2;
            flic_pkg::OFF_FLG0: s_nxt.rdata = s_r.flags[7:0];
            flic_pkg::OFF_FLG1: s_nxt.rdata = s_r.flags[15:8];
            flic_pkg::OFF_FLG2: s_nxt.rdata = {4'h0, s_r.flags[19:16]};
            flic_pkg::OFF_CTRL: s_nxt.rdata = {6'h00, s_r.edge_mode};
            flic_pkg::OFF_STAT: s_nxt.rdata = {1'b0, s_r.phase,
                                               s_r.call_st == flic_pkg::CALL_RUN,
                                               s_r.in_service};
            default: s_nxt.rdata = flic_pkg::RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         s_r <= '0;
         s_r.sync_a1 <= 1'b1;
         s_r.sync_a2 <= 1'b1;
         s_r.sync_b1 <= 1'b1;
         s_r.sync_b2 <= 1'b1;
         s_r.samp_a <= 1'b1;
         s_r.samp_b <= 1'b1;
         s_r.call_st <= flic_pkg::CALL_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_rdata = s_r.rdata;
   assign o_phase = s_r.phase;
   assign o_call_busy = (s_r.call_st == flic_pkg::CALL_RUN);
   assign o_push_pc = s_r.push;
   assign o_load_pc = s_r.load;
   assign o_vector = s_r.vector;
   assign o_wakeup = s_r.wake;
endmodule // flic_top

//--- bench/flic_core_model.sv
`timescale 1ns/1ps
module flic_core_model (
   input wire logic i_core_clk,
   input wire logic i_push,
   input wire logic i_load,
   input wire logic [15:0] i_vector,
   input wire logic i_last_req,
   input wire logic i_blk_req,
   input wire logic i_ret_req,
   output logic o_last_cycle,
   output logic o_instr_blocks,
   output logic o_return_from_interrupt,
   output logic [15:0] o_pc
);
   // core side: instruction boundary, blocking writes, returns, pc
   always_ff @(posedge i_core_clk) begin
      o_last_cycle <= i_last_req;
      o_instr_blocks <= i_blk_req;
      o_return_from_interrupt <= i_ret_req;
      if (i_load && !i_push) begin
         o_pc <= i_vector;
      end
   end
endmodule // flic_core_model

//--- bench/flic_top_sva.sv
`timescale 1ns/1ps
module flic_top_sva (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_last_cycle,
   input wire logic i_instr_blocks,
   input wire logic i_power_down,
   input wire logic [1:0] o_phase,
   input wire logic o_call_busy,
   input wire logic o_push_pc,
   input wire logic o_load_pc,
   input wire logic [15:0] o_vector,
   input wire logic o_wakeup
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);
   AST_LOAD: assert property (o_push_pc |-> ##16 o_load_pc)
      else $error("pc load not sixteen clocks after push");
   AST_BUSY: assert property (
      o_push_pc |-> o_call_busy[*8] ##8 o_call_busy)
      else $error("call busy dropped early");
   AST_STEP: assert property (
      !$past(i_rst) |-> o_phase == $past(o_phase) + 2'h1)
      else $error("phase did not advance");
   AST_PH1: assert property (o_push_pc |-> o_phase == 2'h0)
      else $error("push outside phase one");
   AST_COND: assert property (
      o_push_pc |-> $past(i_last_cycle) && !$past(i_instr_blocks))
      else $error("call granted at wrong instruction point");
   AST_IDLE: assert property (o_push_pc |-> !$past(o_call_busy))
      else $error("call granted while busy");
   AST_HOLD: assert property (o_call_busy && !o_push_pc |-> $stable(o_vector))
      else $error("vector moved during call");
   AST_WAKE: assert property (o_wakeup |-> $past(i_power_down))
      else $error("wakeup outside power down");
endmodule // flic_top_sva
bind flic_top flic_top_sva u_flic_top_sva (
   .i_core_clk(i_core_clk), .i_rst(i_rst), .i_last_cycle(i_last_cycle),
   .i_instr_blocks(i_instr_blocks), .i_power_down(i_power_down),
   .o_phase(o_phase), .o_call_busy(o_call_busy), .o_push_pc(o_push_pc),
   .o_load_pc(o_load_pc), .o_vector(o_vector), .o_wakeup(o_wakeup));

//--- bench/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic pa_n = 1'b1;
   logic pb_n = 1'b1;
   logic [19:0] ev = 20'h00000;
   logic pd = 1'b0;
   logic last_req = 1'b1;
   logic blk_req = 1'b0;
   logic ret_req = 1'b0;
   logic last, blk, return_from_interrupt, busy, push, load, wake;
   logic [7:0] rdata;
   logic [1:0] phase;
   logic [15:0] vector, pc;
   int errors = 0;
   int comparisons = 0;
   initial forever #10 clk = ~clk;
   flic_top u_flic_top (
      .i_core_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_ext_input_a_n(pa_n),
      .i_ext_input_b_n(pb_n), .i_src_event(ev), .i_last_cycle(last),
      .i_instr_blocks(blk), .i_return_from_interrupt(return_from_interrupt), .i_power_down(pd),
      .o_phase(phase), .o_call_busy(busy), .o_push_pc(push),
      .o_load_pc(load), .o_vector(vector), .o_wakeup(wake));
   flic_core_model u_flic_core_model (
      .i_core_clk(clk), .i_push(push), .i_load(load), .i_vector(vector),
      .i_last_req(last_req), .i_blk_req(blk_req), .i_ret_req(ret_req),
      .o_last_cycle(last), .o_instr_blocks(blk), .o_return_from_interrupt(return_from_interrupt), .o_pc(pc));
   task automatic summarize;
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 chk({8'h00, rdata}, {8'h00, exp});
      @(posedge clk);
   endtask
   // bounded watch for a call; a missing wanted call ends the run
   task automatic wp(input logic want, input int n);
      for (int k = 0; k < n && push !== 1'b1; k++) @(negedge clk);
      chk({15'h0000, push}, {15'h0000, want});
      if (want && push !== 1'b1) summarize();
      @(posedge clk);
   endtask
   task automatic take(input logic [15:0] v);
      wp(1'b1, 200);
      chk(vector, v);
      repeat (18) @(posedge clk);
   endtask
   task automatic ret;
      ret_req <= 1'b1;
      @(posedge clk);
      ret_req <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic pulse(input logic [19:0] e);
      ev <= e;
      @(posedge clk);
      ev <= 20'h00000;
   endtask
   task automatic s_vec;
      logic [3:0] ea, fa;
      logic [7:0] eb, fb;
      wr(flic_pkg::OFF_CTRL, 8'h03);
      wr(flic_pkg::OFF_EN0, 8'h80);
      for (int r = 0; r < flic_pkg::NSRC; r++) begin
         ea = {2'h0, flic_pkg::SRC_POS[r][4:3]};
         eb = 8'h01 << flic_pkg::SRC_POS[r][2:0];
         eb = eb | (ea == 4'h0 ? 8'h80 : 8'h00);
         fa = flic_pkg::OFF_FLG0 + 4'(r / 8);
         fb = 8'h01 << (r % 8);
         wr(ea, eb);
         wr(fa, fb);
         take(flic_pkg::SRC_VEC[r]);
         chk(pc, flic_pkg::SRC_VEC[r]);
         fb = ((flic_pkg::TIMER_CLR_MASK | flic_pkg::PIN_SRC_MASK) >> r) & 1
            ? 8'h00 : fb;
         rd(fa, fb);
         wr(fa, 8'h00);
         wr(ea, eb & 8'h80);
         ret();
      end
   endtask
   task automatic s_prio;
      wr(flic_pkg::OFF_EN0, 8'h8A);
      wr(flic_pkg::OFF_PH0, 8'h08);
      wr(flic_pkg::OFF_PL0, 8'h02);
      pulse(20'h0000A);
      take(flic_pkg::SRC_VEC[3]);
      wp(1'b0, 60);
      ret();
      take(flic_pkg::SRC_VEC[1]);
      ret();
      wr(flic_pkg::OFF_PH0, 8'h0A);
      wr(flic_pkg::OFF_PL0, 8'h0A);
      pulse(20'h0000A);
      take(flic_pkg::SRC_VEC[1]);
      wp(1'b0, 60);
      ret();
      take(flic_pkg::SRC_VEC[3]);
      ret();
      wr(flic_pkg::OFF_PH0, 8'h00);
      wr(flic_pkg::OFF_PL0, 8'h00);
   endtask
   task automatic s_gate;
      wr(flic_pkg::OFF_EN0, 8'h80);
      pulse(20'h00008);
      wp(1'b0, 60);
      wr(flic_pkg::OFF_EN0, 8'h08);
      wp(1'b0, 60);
      blk_req <= 1'b1;
      wr(flic_pkg::OFF_EN0, 8'h88);
      wp(1'b0, 60);
      blk_req <= 1'b0;
      last_req <= 1'b0;
      wp(1'b0, 60);
      last_req <= 1'b1;
      take(flic_pkg::SRC_VEC[3]);
      ret();
   endtask
   task automatic s_wake;
      last_req <= 1'b0;
      pd <= 1'b1;
      wr(flic_pkg::OFF_EN0, 8'h82);
      pulse(20'h00002);
      repeat (12) @(posedge clk);
      #1 chk({15'h0000, wake}, 16'h0000);
      wr(flic_pkg::OFF_FLG0, 8'h00);
      wr(flic_pkg::OFF_EN0, 8'h81);
      wr(flic_pkg::OFF_CTRL, 8'h00);
      pa_n <= 1'b0;
      repeat (12) @(posedge clk);
      #1 chk({15'h0000, wake}, 16'h0001);
      @(posedge clk);
      rd(flic_pkg::OFF_FLG0, 8'h01);
      pa_n <= 1'b1;
      pd <= 1'b0;
      repeat (8) @(posedge clk);
      rd(flic_pkg::OFF_FLG0, 8'h00);
      wr(flic_pkg::OFF_FLG0, 8'h00);
      wr(flic_pkg::OFF_EN0, 8'h80);
      last_req <= 1'b1;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(flic_pkg::OFF_EN0, flic_pkg::RST_BYTE);
      rd(4'hE, 8'h00);
      s_vec();
      s_prio();
      s_gate();
      s_wake();
      summarize();
   end
endmodule // testbench
